// File: rtl/bias_seq_pkg.sv
// constants and types shared by the bias rail sequencer
package bias_seq_pkg;

   // time base
   localparam int CLK_PERIOD_NS   = 5;
   localparam int MS_NS           = 1000000;
   localparam int MS_CYCLES       = MS_NS / CLK_PERIOD_NS;
   localparam int DEGLITCH_NS     = 7000;
   localparam int DEGLITCH_CYCLES =
      (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // sequencing and fault timing, in milliseconds
   localparam int SLOT_MS          = 15;
   localparam int UV_TIMEOUT_MS    = 50;
   localparam int NUM_SLOTS        = 4;
   localparam logic [3:0] SLOT_LAST_MS  = 4'(SLOT_MS - 1);
   localparam logic [1:0] SLOT_LAST_IDX = 2'(NUM_SLOTS - 1);
   localparam logic [5:0] UV_EXPIRE_MS  = 6'(UV_TIMEOUT_MS + 1);

   // rail bit positions and masks
   localparam int NUM_RAILS = 4;
   localparam int RAIL_POS  = 0;
   localparam int RAIL_NEG  = 1;
   localparam int RAIL_GLO  = 2;
   localparam int RAIL_GHI  = 3;
   localparam logic [3:0] M_NONE = 4'h0;
   localparam logic [3:0] M_POS  = 4'h1;
   localparam logic [3:0] M_NEG  = 4'h2;
   localparam logic [3:0] M_GLO  = 4'h4;
   localparam logic [3:0] M_GHI  = 4'h8;

   // fault pin duty in quarters of a four-tick period
   localparam logic [1:0] DUTY_OFF   = 2'h0;
   localparam logic [1:0] DUTY_BL    = 2'h1;
   localparam logic [1:0] DUTY_BIAS  = 2'h2;
   localparam logic [1:0] DUTY_THERM = 2'h3;

   // resistor code as delivered by the sense front end
   typedef enum logic [2:0] {
      SEQ_10  = 3'h0,
      SEQ_30  = 3'h1,
      SEQ_51  = 3'h2,
      SEQ_68  = 3'h3,
      SEQ_91  = 3'h4,
      SEQ_110 = 3'h5,
      SEQ_150 = 3'h6
   } seq_code_e;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_SOFT  = 3'h1,
      ST_UP    = 3'h2,
      ST_ON    = 3'h3,
      ST_DOWN  = 3'h4,
      ST_LATCH = 3'h5
   } seq_state_e;

endpackage : bias_seq_pkg

// File: rtl/en_deglitch.sv
// deglitch filter and edge pulses for the enable pin
`timescale 1ns/100ps
module en_deglitch #(
   parameter int STABLE_CYCLES = bias_seq_pkg::DEGLITCH_CYCLES
) (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic raw,
   output logic      level_q,
   output logic      rise_q,
   output logic      fall_q
);
   localparam int CW = $clog2(STABLE_CYCLES);

   logic [CW-1:0] cnt_q;

   if (STABLE_CYCLES < 2) begin : g_bad_param
      $error("en_deglitch: STABLE_CYCLES must be at least 2");
   end

   // filter window
   // any excursion shorter than the window restarts the count
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cnt_q   <= '0;
         level_q <= 1'b0;
         rise_q  <= 1'b0;
         fall_q  <= 1'b0;
      end else begin
         rise_q <= 1'b0;
         fall_q <= 1'b0;
         if (raw == level_q) begin
            cnt_q <= '0;
         end else if (cnt_q == CW'(STABLE_CYCLES - 1)) begin
            cnt_q   <= '0;
            level_q <= raw;
            rise_q  <= raw;
            fall_q  <= ~raw;
         end else begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end

endmodule : en_deglitch

// File: rtl/tft_bias_rail_sequencer.sv
// sequencing and fault supervision of the display bias rails
`timescale 1ns/100ps
module tft_bias_rail_sequencer #(
   parameter int MS_CYCLES       = bias_seq_pkg::MS_CYCLES,
   parameter int DEGLITCH_CYCLES = bias_seq_pkg::DEGLITCH_CYCLES
) (
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       host_mode,
   input  wire logic [2:0] sequence_select_code,
   input  wire logic       en_pin,
   input  wire logic [3:0] host_rail_en,
   input  wire logic       host_boost_en,
   input  wire logic       boost_ss_done,
   input  wire logic [3:0] rail_pgood,
   input  wire logic [3:0] rail_short,
   input  wire logic       bias_hot,
   input  wire logic       bias_cooled,
   input  wire logic       bl_hot,
   input  wire logic       bl_cooled,
   input  wire logic       bl_fault,
   input  wire logic       fault_flag_out_i,
   output logic [3:0]      rail_en_q,
   output logic            boost_input_rail_en_q,
   output logic            backlight_en_q,
   output logic [3:0]      rail_fault_q,
   output logic            fault_flag_out_o,
   output logic            fault_flag_out_oe_n
);
   localparam int TICK_W = $clog2(MS_CYCLES);

   if (MS_CYCLES < 2) begin : g_bad_param
      $error("tft_bias_rail_sequencer: MS_CYCLES must be at least 2");
   end

   bias_seq_pkg::seq_code_e  code;
   bias_seq_pkg::seq_state_e state_q;
   logic [TICK_W-1:0]        tick_cnt_q;
   logic [3:0]               slot_ms_q;
   logic [1:0]               slot_q;
   logic [3:0]               seq_rails_q;
   logic [1:0]               phase_q;
   logic                     bias_therm_q;
   logic                     bl_therm_q;
   logic                     en_level;
   logic                     en_rise;
   logic                     en_fall;
   logic                     tick;
   logic                     slot_fire;
   logic                     restart;
   logic                     bias_kill;
   logic                     sa_fault_now;
   logic [3:0]               uv_exp;
   logic [3:0]               rail_hit;
   logic [3:0]               host_fset;
   logic [3:0]               rail_en_d;
   logic                     boost_d;
   logic                     all_good;
   logic                     bl_ready;
   logic [1:0]               duty;
   logic                     fault_drive;

   // power-up order per code, slot 0 in the low nibble
   // three-rail codes leave the top slot empty
   // code 110 enables rails in pairs
   function automatic logic [15:0] up_order(
      input bias_seq_pkg::seq_code_e c);
      case (c)
         bias_seq_pkg::SEQ_10:  up_order = {bias_seq_pkg::M_GHI,
            bias_seq_pkg::M_GLO, bias_seq_pkg::M_NEG, bias_seq_pkg::M_POS};
         bias_seq_pkg::SEQ_30:  up_order = {bias_seq_pkg::M_GLO,
            bias_seq_pkg::M_GHI, bias_seq_pkg::M_NEG, bias_seq_pkg::M_POS};
         bias_seq_pkg::SEQ_51:  up_order = {bias_seq_pkg::M_GHI,
            bias_seq_pkg::M_GLO, bias_seq_pkg::M_POS, bias_seq_pkg::M_NEG};
         bias_seq_pkg::SEQ_68:  up_order = {bias_seq_pkg::M_NONE,
            bias_seq_pkg::M_GHI, bias_seq_pkg::M_GLO, bias_seq_pkg::M_POS};
         bias_seq_pkg::SEQ_91:  up_order = {bias_seq_pkg::M_NONE,
            bias_seq_pkg::M_GLO, bias_seq_pkg::M_GHI, bias_seq_pkg::M_POS};
         bias_seq_pkg::SEQ_110: up_order = {
            bias_seq_pkg::M_GLO | bias_seq_pkg::M_GHI,
            bias_seq_pkg::M_NONE, bias_seq_pkg::M_NONE,
            bias_seq_pkg::M_POS | bias_seq_pkg::M_NEG};
         bias_seq_pkg::SEQ_150: up_order = {bias_seq_pkg::M_POS,
            bias_seq_pkg::M_NEG, bias_seq_pkg::M_GHI, bias_seq_pkg::M_GLO};
         default:               up_order = '0;
      endcase
   endfunction : up_order

   // power-down walks the power-up order backwards
   function automatic logic [3:0] slot_mask(
      input bias_seq_pkg::seq_code_e c,
      input logic [1:0]              slot,
      input logic                    down);
      logic [15:0] ord;
      logic [1:0]  idx;
      ord = up_order(c);
      if (!down) begin
         idx = slot;
      end else if (c == bias_seq_pkg::SEQ_68 ||
                   c == bias_seq_pkg::SEQ_91) begin
         // three rails: down slots 0..2 mirror up slots 2..0
         idx = 2'h2 - slot;
      end else begin
         idx = ~slot;
      end
      slot_mask = ord[idx*4 +: 4];
   endfunction : slot_mask

   assign code = bias_seq_pkg::seq_code_e'(sequence_select_code);

   en_deglitch #(
      .STABLE_CYCLES(DEGLITCH_CYCLES)
   ) u_en_deglitch (
      .ref_clk(ref_clk),
      .rst    (rst),
      .raw    (en_pin),
      .level_q(en_level),
      .rise_q (en_rise),
      .fall_q (en_fall)
   );

   // millisecond tick, restarted with each sequence
   assign tick = tick_cnt_q == TICK_W'(MS_CYCLES - 1);
   assign restart = !host_mode &&
      ((state_q == bias_seq_pkg::ST_IDLE && en_rise) ||
       (state_q == bias_seq_pkg::ST_SOFT && boost_ss_done && !en_fall) ||
       ((state_q == bias_seq_pkg::ST_UP ||
         state_q == bias_seq_pkg::ST_ON) && en_fall));

   always_ff @(posedge ref_clk) begin
      if (rst || restart || tick) begin
         tick_cnt_q <= '0;
      end else begin
         tick_cnt_q <= tick_cnt_q + 1'b1;
      end
   end

   // slots every 15 ms from the sequence start
   assign slot_fire = tick && slot_ms_q == bias_seq_pkg::SLOT_LAST_MS;

   always_ff @(posedge ref_clk) begin
      if (rst || restart) begin
         slot_ms_q <= '0;
         slot_q    <= '0;
      end else if (slot_fire) begin
         slot_ms_q <= '0;
         slot_q    <= slot_q + 1'b1;
      end else if (tick) begin
         slot_ms_q <= slot_ms_q + 1'b1;
      end
   end

   for (genvar i = 0; i < bias_seq_pkg::NUM_RAILS; i++) begin : g_uv
      logic [5:0] uv_ms_q;
      always_ff @(posedge ref_clk) begin
         if (rst || !rail_en_q[i] || rail_pgood[i]) begin
            uv_ms_q <= '0;
         end else if (tick && uv_ms_q != bias_seq_pkg::UV_EXPIRE_MS) begin
            uv_ms_q <= uv_ms_q + 1'b1;
         end
      end
      assign uv_exp[i] = uv_ms_q == bias_seq_pkg::UV_EXPIRE_MS;
   end

   // a short counts on its first cycle, no filtering
   assign rail_hit     = (rail_short & rail_en_q) | uv_exp;
   assign sa_fault_now = !host_mode && (|rail_hit);
   assign host_fset    = {4{host_mode}} & host_rail_en & rail_hit;
   assign bias_kill    = bias_therm_q | bias_hot;

   always_ff @(posedge ref_clk) begin
      if (rst || host_mode) begin
         // enable pin has no effect in host mode
         state_q     <= bias_seq_pkg::ST_IDLE;
         seq_rails_q <= bias_seq_pkg::M_NONE;
      end else if (sa_fault_now) begin
         // latch everything at once, no down sequence
         state_q     <= bias_seq_pkg::ST_LATCH;
         seq_rails_q <= bias_seq_pkg::M_NONE;
      end else begin
         unique case (state_q)
            bias_seq_pkg::ST_IDLE: begin
               if (en_rise) begin
                  state_q <= bias_seq_pkg::ST_SOFT;
               end
            end
            bias_seq_pkg::ST_SOFT: begin
               if (en_fall) begin
                  state_q <= bias_seq_pkg::ST_IDLE;
               end else if (boost_ss_done) begin
                  state_q <= bias_seq_pkg::ST_UP;
               end
            end
            bias_seq_pkg::ST_UP: begin
               if (en_fall) begin
                  state_q <= bias_seq_pkg::ST_DOWN;
               end else if (slot_fire) begin
                  seq_rails_q <= seq_rails_q | slot_mask(code, slot_q, 1'b0);
                  if (slot_q == bias_seq_pkg::SLOT_LAST_IDX) begin
                     state_q <= bias_seq_pkg::ST_ON;
                  end
               end
            end
            bias_seq_pkg::ST_ON: begin
               if (en_fall) begin
                  state_q <= bias_seq_pkg::ST_DOWN;
               end
            end
            bias_seq_pkg::ST_DOWN: begin
               if (slot_fire) begin
                  seq_rails_q <= seq_rails_q & ~slot_mask(code, slot_q, 1'b1);
                  if (slot_q == bias_seq_pkg::SLOT_LAST_IDX) begin
                     state_q <= bias_seq_pkg::ST_IDLE;
                  end
               end
            end
            bias_seq_pkg::ST_LATCH: begin
               // a low enable or host mode releases the latch
               if (!en_level) begin
                  state_q <= bias_seq_pkg::ST_IDLE;
               end
            end
            default: begin
               state_q <= bias_seq_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // thermal flags clear on the cooled indication
   // separate flags so a backlight trip leaves the bias section on; a bias trip also drops the backlight
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         bias_therm_q <= 1'b0;
      end else if (bias_hot) begin
         bias_therm_q <= 1'b1;
      end else if (bias_cooled) begin
         bias_therm_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         bl_therm_q <= 1'b0;
      end else if (bl_hot) begin
         bl_therm_q <= 1'b1;
      end else if (bl_cooled) begin
         bl_therm_q <= 1'b0;
      end
   end

   // fault clears with the enable bit, set and clear exclusive
   // stand-alone keeps the offending rails visible until idle
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rail_fault_q <= '0;
      end else if (host_mode) begin
         rail_fault_q <= (rail_fault_q & host_rail_en) | host_fset;
      end else if (state_q == bias_seq_pkg::ST_IDLE) begin
         rail_fault_q <= '0;
      end else begin
         rail_fault_q <= rail_fault_q | rail_hit;
      end
   end

   always_comb begin
      if (host_mode) begin
         // a faulted rail is held off without its neighbours
         // no rail before boost soft-start completes
         rail_en_d = host_rail_en & ~rail_fault_q & ~host_fset &
                     {4{boost_input_rail_en_q & boost_ss_done}};
         // a rail request also wakes the boost rail
         boost_d   = host_boost_en | (|host_rail_en);
      end else begin
         rail_en_d = sa_fault_now ? bias_seq_pkg::M_NONE : seq_rails_q;
         boost_d   = !sa_fault_now &&
                     state_q != bias_seq_pkg::ST_IDLE &&
                     state_q != bias_seq_pkg::ST_LATCH;
      end
   end

   // bias thermal trip drops the whole bias section
   always_ff @(posedge ref_clk) begin
      if (rst || bias_kill) begin
         rail_en_q             <= '0;
         boost_input_rail_en_q <= 1'b0;
      end else begin
         rail_en_q             <= rail_en_d;
         boost_input_rail_en_q <= boost_d;
      end
   end

   // backlight waits for every enabled rail power-good
   assign all_good = rail_en_q != '0 &&
                     (rail_pgood & rail_en_q) == rail_en_q;
   assign bl_ready = host_mode ? rail_en_q == (host_rail_en & ~rail_fault_q)
                               : state_q == bias_seq_pkg::ST_ON;

   // backlight trip leaves the bias rails alone
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         backlight_en_q <= 1'b0;
      end else begin
         backlight_en_q <= all_good && bl_ready && !bl_therm_q &&
                           !bl_hot && !bias_kill;
      end
   end

   // duty in quarter periods, bias latch has priority
   always_comb begin
      if (state_q == bias_seq_pkg::ST_LATCH) begin
         duty = bias_seq_pkg::DUTY_BIAS;
      end else if (bias_therm_q) begin
         duty = bias_seq_pkg::DUTY_THERM;
      end else if (bl_therm_q || bl_fault) begin
         duty = bias_seq_pkg::DUTY_BL;
      end else begin
         duty = bias_seq_pkg::DUTY_OFF;
      end
   end

   // host mode holds the pin low while faulted
   assign fault_drive = host_mode ?
      (|rail_fault_q) || bias_therm_q || bl_therm_q || bl_fault :
      phase_q < duty;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         phase_q <= '0;
      end else if (tick) begin
         phase_q <= phase_q + 1'b1;
      end
   end

   // open drain: only ever pulls low
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fault_flag_out_o    <= 1'b0;
         fault_flag_out_oe_n <= 1'b1;
      end else begin
         fault_flag_out_o    <= 1'b0;
         fault_flag_out_oe_n <= !fault_drive;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   boost_first_a: assert property (
      rail_en_q != '0 |-> boost_input_rail_en_q)
      else $error("rail on without boost input rail");

   ss_wait_a: assert property (
      host_mode && (rail_en_q & ~$past(rail_en_q)) != '0
      |-> $past(boost_ss_done) && $past(boost_input_rail_en_q))
      else $error("rail enabled before boost soft-start done");

   uv_latch_a: assert property (
      !host_mode && (|uv_exp)
      |=> state_q == bias_seq_pkg::ST_LATCH && rail_en_q == '0)
      else $error("undervoltage timeout did not latch off");

   short_latch_a: assert property (
      !host_mode && (|(rail_short & rail_en_q))
      |=> rail_en_q == '0 && !boost_input_rail_en_q
          && state_q == bias_seq_pkg::ST_LATCH)
      else $error("short did not latch all rails off");

   latch_hold_a: assert property (
      state_q == bias_seq_pkg::ST_LATCH && en_level && !host_mode
      |=> state_q == bias_seq_pkg::ST_LATCH && rail_en_q == '0)
      else $error("latched fault released with enable high");

   host_isolate_a: assert property (
      host_mode && host_rail_en[0] && rail_en_q[0] && rail_short[0]
      |=> !rail_en_q[0] && rail_fault_q[0])
      else $error("faulted rail not isolated in host mode");

   fault_clear_a: assert property (
      host_mode && !host_rail_en[1] |=> !rail_fault_q[1])
      else $error("rail fault not cleared by enable bit low");

   bias_therm_a: assert property (
      bias_hot |=> rail_en_q == '0 && !boost_input_rail_en_q
                   ##1 bias_therm_q || bias_cooled)
      else $error("bias thermal trip did not stop bias section");

   bl_therm_a: assert property (
      bl_hot |=> !backlight_en_q)
      else $error("backlight thermal trip did not stop backlight");

   therm_clear_a: assert property (
      bias_therm_q && bias_cooled && !bias_hot |=> !bias_therm_q)
      else $error("bias thermal flag not cleared when cooled");

   host_pin_a: assert property (
      host_mode && (|rail_fault_q) |=> !fault_flag_out_oe_n)
      else $error("fault pin not low while host-mode fault");

   host_idle_a: assert property (
      host_mode |=> state_q == bias_seq_pkg::ST_IDLE && !restart)
      else $error("sequencer ran in host mode");

   backlight_good_a: assert property (
      backlight_en_q |-> $past(rail_en_q) != '0 &&
         ($past(rail_pgood) & $past(rail_en_q)) == $past(rail_en_q))
      else $error("backlight on before rails power-good");

   seq_on_c: cover property (
      !host_mode && state_q == bias_seq_pkg::ST_ON && backlight_en_q);
   seq_latch_c: cover property (state_q == bias_seq_pkg::ST_LATCH);
   host_fault_c: cover property (host_mode && (|rail_fault_q));
   pin_low_c: cover property (!fault_flag_out_i && !host_mode);

endmodule : tft_bias_rail_sequencer

// File: verification/rail_plant.sv
// far-side model of the bias rails, boost converter and fault line
`timescale 1ns/100ps
module rail_plant (
   input  wire logic       ref_clk,
   input  wire logic [3:0] rail_en,
   input  wire logic       boost_en,
   input  wire logic [3:0] short_cmd,
   input  wire logic [3:0] uv_cmd,
   input  wire logic       pin_o,
   input  wire logic       pin_oe_n,
   output logic            ss,
   output logic [3:0]      pgood,
   output logic [3:0]      short_det,
   output logic            pin
);
   logic [3:0] ss_q;
   logic [3:0] on_q [0:4];
   always_ff @(posedge ref_clk) begin
      if (!boost_en) ss_q <= 4'h0;
      else if (ss_q != 4'ha) ss_q <= ss_q + 4'h1;
   end
   assign ss = (ss_q == 4'ha);
   // power-good lags enable, drops on uv
   always_ff @(posedge ref_clk) begin
      on_q[0] <= rail_en;
      for (int i = 1; i < 5; i++) on_q[i] <= on_q[i-1] & rail_en;
   end
   assign pgood = on_q[4] & rail_en & ~uv_cmd & ~short_cmd;
   // short seen at once, however brief
   assign short_det = short_cmd;
   // pull-up holds the open-drain line high when released
   assign pin = pin_oe_n ? 1'b1 : pin_o;
endmodule : rail_plant

// File: verification/tb_tft_bias_rail_sequencer.sv
// self-checking bench for the bias rail sequencer
`timescale 1ns/100ps
module tb_tft_bias_rail_sequencer;
   localparam int MSC = 20;
   localparam int SLOT = 15 * MSC;
   logic       ref_clk = 1'b0;
   logic       rst = 1'b1;
   logic       hm = 1'b0;
   logic [2:0] code = 3'h0;
   logic       en = 1'b0;
   logic [3:0] hr = 4'h0;
   logic [3:0] sh = 4'h0;
   logic [3:0] uv = 4'h0;
   logic       b_hot = 1'b0;
   logic       b_cool = 1'b0;
   logic       l_hot = 1'b0;
   logic       l_cool = 1'b0;
   logic       hb = 1'b0;
   logic       l_flt = 1'b0;
   logic       ss, pin, bst, bl, p_o, p_oe_n;
   logic [3:0] pg, sd, re, rf;
   int         mismatches = 0;
   int         cmp_count = 0;
   int         cycles = 0;

   always #2.5 ref_clk = ~ref_clk;

   tft_bias_rail_sequencer #(.MS_CYCLES(MSC), .DEGLITCH_CYCLES(4)) uut (
      .ref_clk(ref_clk), .rst(rst), .host_mode(hm),
      .sequence_select_code(code), .en_pin(en), .host_rail_en(hr),
      .host_boost_en(hb), .boost_ss_done(ss), .rail_pgood(pg),
      .rail_short(sd), .bias_hot(b_hot), .bias_cooled(b_cool),
      .bl_hot(l_hot), .bl_cooled(l_cool), .bl_fault(l_flt),
      .fault_flag_out_i(pin), .rail_en_q(re),
      .boost_input_rail_en_q(bst), .backlight_en_q(bl),
      .rail_fault_q(rf), .fault_flag_out_o(p_o),
      .fault_flag_out_oe_n(p_oe_n));

   rail_plant plant (
      .ref_clk(ref_clk), .rail_en(re), .boost_en(bst), .short_cmd(sh),
      .uv_cmd(uv), .pin_o(p_o), .pin_oe_n(p_oe_n), .ss(ss), .pgood(pg),
      .short_det(sd), .pin(pin));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wrap_up();
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : wrap_up

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : cyc

   // bounded wait on soft-start, then into the slot grid
   task automatic wss(input int n);
      for (int i = 0; i < 99 && ss !== 1'b1; i++) cyc(1);
      cyc(n);
   endtask : wss

   // per code, slot k rails in nibble k
   function automatic logic [3:0] cum(input logic [2:0] c, input int n);
      logic [15:0] o;
      case (c)
         3'h0: o = 16'h8421;
         3'h1: o = 16'h4821;
         3'h2: o = 16'h8412;
         3'h3: o = 16'h0841;
         3'h4: o = 16'h0481;
         3'h5: o = 16'hc003;
         3'h6: o = 16'h1284;
         default: o = 16'h0000;
      endcase
      cum = 4'h0;
      for (int i = 0; i < n; i++) cum = cum | o[i*4 +: 4];
   endfunction : cum

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         mismatches++;
         wrap_up();
      end
   end

   initial begin
      logic [3:0] m, b;
      int lows, last;
      m = 4'($urandom(31));
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk) en <= 1'b1;
      @(posedge ref_clk);
      @(posedge ref_clk) en <= 1'b0;
      cyc(30);
      chk(16'(bst), 16'h0);
      for (int c = 0; c < 7; c++) begin
         last = (c == 3 || c == 4) ? 3 : 4;
         @(posedge ref_clk) begin
            code <= 3'(c);
            en <= 1'b1;
         end
         wss(SLOT / 2);
         chk(16'(bst), 16'h1);
         for (int k = 0; k < 5; k++) begin
            chk(16'(re), 16'(cum(code, k)));
            cyc(SLOT);
         end
         chk(16'(bl), 16'h1);
         @(posedge ref_clk) en <= 1'b0;
         cyc(SLOT / 2);
         for (int j = 0; j < 4; j++) begin
            cyc(SLOT);
            chk(16'(re), 16'(cum(code, last - j - 1)));
         end
         cyc(SLOT);
         chk(16'(bst), 16'h0);
      end
      @(posedge ref_clk) begin
         code <= 3'h0;
         en <= 1'b1;
      end
      wss(SLOT + 20);
      @(posedge ref_clk) uv <= 4'h1;
      cyc(48 * MSC);
      chk(16'(bst), 16'h1);
      cyc(5 * MSC);
      chk(16'({bst, re}), 16'h0);
      @(posedge ref_clk) uv <= 4'h0;
      lows = 0;
      for (int i = 0; i < 16 * MSC; i++) begin
         cyc(1);
         lows += (pin === 1'b0);
      end
      chk(16'(bst), 16'h0);
      chk(16'(lows >= 6 * MSC && lows <= 10 * MSC), 16'h1);
      @(posedge ref_clk) en <= 1'b0;
      cyc(20);
      @(posedge ref_clk) en <= 1'b1;
      wss(SLOT + 20);
      chk(16'(re), 16'h1);
      @(posedge ref_clk) sh <= 4'h1;
      @(posedge ref_clk) sh <= 4'h0;
      cyc(3);
      chk(16'({bst, re}), 16'h0);
      @(posedge ref_clk) begin
         en <= 1'b0;
         hm <= 1'b1;
      end
      cyc(30);
      @(posedge ref_clk) en <= 1'b1;
      cyc(30);
      chk(16'(bst), 16'h0);
      // boost rail alone on its own bit, no rail follows
      @(posedge ref_clk) hb <= 1'b1;
      cyc(20);
      chk(16'({bst, re}), 16'h10);
      @(posedge ref_clk) hb <= 1'b0;
      cyc(5);
      chk(16'(bst), 16'h0);
      for (int r = 0; r < 4; r++) begin
         // first pass takes every rail at once
         if (r == 0) m = 4'hf;
         else m = 4'($urandom());
         if (m == 4'h0) m = 4'h5;
         b = m & (~m + 4'h1);
         @(posedge ref_clk) hr <= m;
         cyc(2);
         chk(16'({bst, re}), 16'h10);
         cyc(30);
         chk(16'({bst, bl, re}), 16'({2'b11, m}));
         @(posedge ref_clk) sh <= b;
         @(posedge ref_clk) sh <= 4'h0;
         cyc(3);
         chk(16'({pin, rf, re}), 16'({1'b0, b, m & ~b}));
         cyc(20);
         chk(16'(re), 16'(m & ~b));
         @(posedge ref_clk) hr <= m & ~b;
         cyc(3);
         chk(16'({pin, rf}), 16'h10);
         @(posedge ref_clk) hr <= 4'h0;
         cyc(30);
      end
      @(posedge ref_clk) hr <= 4'hf;
      cyc(40);
      @(posedge ref_clk) l_flt <= 1'b1;
      cyc(3);
      chk(16'(pin), 16'h0);
      @(posedge ref_clk) l_flt <= 1'b0;
      cyc(3);
      chk(16'(pin), 16'h1);
      @(posedge ref_clk) l_hot <= 1'b1;
      cyc(3);
      chk(16'({bl, re}), 16'h0f);
      @(posedge ref_clk) begin
         l_hot <= 1'b0;
         l_cool <= 1'b1;
         b_hot <= 1'b1;
      end
      cyc(3);
      chk(16'({bst, re}), 16'h0);
      @(posedge ref_clk) begin
         b_hot <= 1'b0;
         b_cool <= 1'b1;
      end
      cyc(30);
      chk(16'({bst, bl, re}), 16'h3f);
      wrap_up();
   end
endmodule : tb_tft_bias_rail_sequencer
